//--- mlbu_loop_unit.sv
// How it works
// - counted top branch with loop count zero and epilog count one: decrement, rotate, fall through
// - after final counted rotation epilog count and first-stage predicate read zero
// - while branch ignores loop count; predicate plus epilog count decide
// - while branch always leaves first-stage predicate zero after rotation
// - rotation is renaming by a readable base that decrements each step
// - counted branch decides in one cycle, via loop count then epilog count
// - one loop branch and one rotation per initiation interval stage
// - counted branch with nonzero loop count: predicate one, loop count down, epilog kept
// - exhausted loop count: predicate zero, epilog count down each time it is above zero
// - fr and pr bases, and gr base unless its area is zero, decrement together in one step
// - while branch with zero predicate continues only if epilog count above one
`timescale 1ns/1ps
module mlbu_loop_unit (
  input  wire logic        sys_clk,     // core clock
  input  wire logic        rst_n,       // sync reset, active low
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb access phase
  input  wire logic        pwrite,      // apb direction
  input  wire logic [7:0]  paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  input  wire logic [3:0]  pstrb,       // apb byte strobes
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error
  output logic             branchTaken, // pulse: last branch taken
  output logic             loopExit     // pulse: kernel loop left
);

  localparam int LCW  = mlbu_pkg::LCW;
  localparam int ECW  = mlbu_pkg::ECW;
  localparam int RRBW = mlbu_pkg::RRBW;
  localparam int PRN  = mlbu_pkg::PRN;
  localparam int IIW  = mlbu_pkg::IIW;

  // =====================================================
  // helpers
  // wrap inside the rotating area
  // zero-sized area never rotates, base stays pinned
  function automatic logic [RRBW-1:0] decWrap(input logic [RRBW-1:0] rrb, input logic [RRBW-1:0] size);
    if (size == mlbu_pkg::RRB_RST) begin
      decWrap = mlbu_pkg::RRB_RST;
    end else if (rrb == mlbu_pkg::RRB_RST) begin
      decWrap = size - mlbu_pkg::RRB_ONE;
    end else begin
      decWrap = rrb - mlbu_pkg::RRB_ONE;
    end
  endfunction

  // logical p16 is index 0 of the rotating block
  function automatic int physIdx(input int logical, input logic [RRBW-1:0] rrb);
    physIdx = (logical + int'(rrb)) % PRN;
  endfunction

  // reads follow the base; initial writes stay physical
  function automatic logic [PRN-1:0] logicalView(input logic [PRN-1:0] phys, input logic [RRBW-1:0] rrb);
    for (int i = 0; i < PRN; i++) begin
      logicalView[i] = phys[physIdx(i, rrb)];
    end
  endfunction

  // =====================================================
  // state
  logic [LCW-1:0]       lcQ, lcD;
  logic [ECW-1:0]       ecQ, ecD;
  logic [RRBW-1:0]      rrbGrQ, rrbGrD;
  logic [RRBW-1:0]      rrbFrQ, rrbFrD;
  logic [RRBW-1:0]      rrbPrQ, rrbPrD;
  logic [RRBW-1:0]      grSizeQ, grSizeD;
  logic [PRN-1:0]       predQ, predD;
  logic [IIW-1:0]       iiQ, iiD;
  logic [IIW-1:0]       cycQ, cycD;
  mlbu_pkg::mlbu_phase_t phaseQ, phaseD;
  logic                 takenQ, takenD;
  logic                 exitQ, exitD;
  logic                 misQ, misD;
  logic                 takenPQ, takenPD;
  logic                 exitPQ, exitPD;
  logic [31:0]          prdataQ, prdataD;
  logic                 preadyQ, preadyD;
  logic                 pslverrQ, pslverrD;

  logic                 setup;
  logic                 wrEn;
  logic                 branchGo;
  logic [PRN-1:0]       predView;
  logic [RRBW-1:0]      wrGrSize;
  logic                 badGrSize;

  mlbu_br_if br ();

  mlbu_branch_eval u_eval (
    .br (br.eval)
  );

  // =====================================================
  // apb slave
  assign setup     = psel && !penable;
  // refused writes never touch the state
  assign wrEn      = psel && penable && pwrite && preadyQ && !pslverrQ;
  assign branchGo  = wrEn && (paddr == mlbu_pkg::OFF_BRANCH);
  assign predView  = logicalView(predQ, rrbPrQ);
  assign wrGrSize  = pwdata[RRBW-1:0];
  // gr area: zero or whole groups of eight, capped
  assign badGrSize = (wrGrSize > 7'(mlbu_pkg::GRMAX)) || (wrGrSize % 7'(mlbu_pkg::GR_GRAIN) != 7'h00);

  // zero wait states: answer prepared in setup, pready high in access
  always_comb begin
    preadyD  = setup;
    prdataD  = prdataQ;
    pslverrD = 1'b0;
    if (setup) begin
      prdataD = 32'h0000_0000;
      if (pwrite && (pstrb != mlbu_pkg::STRB_ALL)) begin
        // partial writes would split counters mid-loop
        pslverrD = 1'b1;
      end else if (paddr == mlbu_pkg::OFF_BRANCH) begin
        pslverrD = 1'b0;
      end else if (paddr == mlbu_pkg::OFF_LOOPCNT) begin
        prdataD = lcQ;
      end else if (paddr == mlbu_pkg::OFF_EPICNT) begin
        prdataD[ECW-1:0] = ecQ;
      end else if (paddr == mlbu_pkg::OFF_RRB) begin
        prdataD[mlbu_pkg::RRB_GR_LSB +: RRBW] = rrbGrQ;
        prdataD[mlbu_pkg::RRB_FR_LSB +: RRBW] = rrbFrQ;
        prdataD[mlbu_pkg::RRB_PR_LSB +: RRBW] = rrbPrQ;
      end else if (paddr == mlbu_pkg::OFF_GRSIZE) begin
        prdataD[RRBW-1:0] = grSizeQ;
        pslverrD          = pwrite && badGrSize;
      end else if (paddr == mlbu_pkg::OFF_PREDLO) begin
        prdataD = predView[mlbu_pkg::PRED_LO_W-1:0];
      end else if (paddr == mlbu_pkg::OFF_PREDHI) begin
        prdataD[PRN-mlbu_pkg::PRED_LO_W-1:0] = predView[PRN-1:mlbu_pkg::PRED_LO_W];
      end else if (paddr == mlbu_pkg::OFF_STATUS) begin
        prdataD[mlbu_pkg::ST_TAKEN]          = takenQ;
        prdataD[mlbu_pkg::ST_EXIT]           = exitQ;
        prdataD[mlbu_pkg::ST_PHASE_LSB +: 2] = phaseQ;
        prdataD[mlbu_pkg::ST_MISALIGN]       = misQ;
      end else if (paddr == mlbu_pkg::OFF_IIVAL) begin
        prdataD[IIW-1:0] = iiQ;
        pslverrD         = pwrite && (pwdata[IIW-1:0] == 8'h00);
      end else begin
        pslverrD = 1'b1;
      end
    end
  end

  // =====================================================
  // branch request to the decision logic
  assign br.op = mlbu_pkg::mlbu_op_t'(pwdata[mlbu_pkg::BR_OP_LSB +: 2]);
  assign br.qp = pwdata[mlbu_pkg::BR_QP_BIT];
  // while variants only see the counter, never write it
  assign br.lc = lcQ;
  assign br.ec = ecQ;

  // =====================================================
  // loop state update
  always_comb begin
    lcD     = lcQ;
    ecD     = ecQ;
    rrbGrD  = rrbGrQ;
    rrbFrD  = rrbFrQ;
    rrbPrD  = rrbPrQ;
    grSizeD = grSizeQ;
    predD   = predQ;
    iiD     = iiQ;
    phaseD  = phaseQ;
    takenD  = takenQ;
    exitD   = exitQ;
    misD    = misQ;
    takenPD = 1'b0;
    exitPD  = 1'b0;
    // saturate so a long stall cannot wrap into a false match
    cycD    = (cycQ == mlbu_pkg::CYC_MAX) ? cycQ : cycQ + mlbu_pkg::CYC_ONE;
    if (wrEn) begin
      if (paddr == mlbu_pkg::OFF_LOOPCNT) begin
        lcD = pwdata;
      end else if (paddr == mlbu_pkg::OFF_EPICNT) begin
        ecD = pwdata[ECW-1:0];
      end else if (paddr == mlbu_pkg::OFF_RRB) begin
        rrbGrD = pwdata[mlbu_pkg::RRB_GR_LSB +: RRBW];
        rrbFrD = pwdata[mlbu_pkg::RRB_FR_LSB +: RRBW];
        rrbPrD = pwdata[mlbu_pkg::RRB_PR_LSB +: RRBW];
      end else if (paddr == mlbu_pkg::OFF_GRSIZE) begin
        grSizeD = wrGrSize;
        rrbGrD  = mlbu_pkg::RRB_RST;
      end else if (paddr == mlbu_pkg::OFF_PREDLO) begin
        // initialiser ignores the predicate base, writes physical bits
        predD[mlbu_pkg::PRED_LO_W-1:0] = pwdata;
      end else if (paddr == mlbu_pkg::OFF_PREDHI) begin
        predD[PRN-1:mlbu_pkg::PRED_LO_W] = pwdata[PRN-mlbu_pkg::PRED_LO_W-1:0];
      end else if (paddr == mlbu_pkg::OFF_IIVAL) begin
        iiD = pwdata[IIW-1:0];
      end else if (paddr == mlbu_pkg::OFF_STATUS) begin
        // write one to clear the sticky misalign flag
        misD = misQ && !pwdata[mlbu_pkg::ST_MISALIGN];
      end
    end
    // branch commit: results come from the decision logic
    if (branchGo) begin
      lcD     = br.lcNext;
      ecD     = br.ecNext;
      takenD  = br.taken;
      exitD   = !br.cont;
      takenPD = br.taken;
      exitPD  = !br.cont;
      cycD    = mlbu_pkg::CYC_RST;
      // stage length must equal the initiation interval
      // flagged only; the branch still executes
      if ((phaseQ != mlbu_pkg::PH_IDLE) && (cycQ != iiQ - mlbu_pkg::CYC_ONE)) begin
        misD = 1'b1;
      end
      if (br.rotate) begin
        // while variants always write zero here
        // final rotation shifts in a zero
        predD[physIdx(PRN - 1, rrbPrQ)] = br.newPred;
        rrbGrD = decWrap(rrbGrQ, grSizeQ);
        rrbFrD = decWrap(rrbFrQ, 7'(mlbu_pkg::FRN));
        rrbPrD = decWrap(rrbPrQ, 7'(PRN));
      end
      case (phaseQ)
        mlbu_pkg::PH_IDLE: begin
          phaseD = br.cont ? mlbu_pkg::PH_RUN : mlbu_pkg::PH_IDLE;
        end
        mlbu_pkg::PH_RUN: begin
          if (!br.cont) begin
            phaseD = mlbu_pkg::PH_IDLE;
          end else if (!br.newPred) begin
            phaseD = mlbu_pkg::PH_DRAIN;
          end
        end
        mlbu_pkg::PH_DRAIN: begin
          phaseD = br.cont ? mlbu_pkg::PH_DRAIN : mlbu_pkg::PH_IDLE;
        end
        default: begin
          phaseD = mlbu_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // =====================================================
  // registers
  // synchronous reset parks every flop at its idle value
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lcQ      <= mlbu_pkg::LC_RST;
      ecQ      <= mlbu_pkg::EC_RST;
      rrbGrQ   <= mlbu_pkg::RRB_RST;
      rrbFrQ   <= mlbu_pkg::RRB_RST;
      rrbPrQ   <= mlbu_pkg::RRB_RST;
      grSizeQ  <= mlbu_pkg::GRSIZE_RST;
      predQ    <= '0;
      iiQ      <= mlbu_pkg::II_RST;
      cycQ     <= mlbu_pkg::CYC_RST;
      phaseQ   <= mlbu_pkg::PH_IDLE;
      takenQ   <= 1'b0;
      exitQ    <= 1'b0;
      misQ     <= 1'b0;
      takenPQ  <= 1'b0;
      exitPQ   <= 1'b0;
      prdataQ  <= 32'h0000_0000;
      preadyQ  <= 1'b0;
      pslverrQ <= 1'b0;
    end else begin
      lcQ      <= lcD;
      ecQ      <= ecD;
      rrbGrQ   <= rrbGrD;
      rrbFrQ   <= rrbFrD;
      rrbPrQ   <= rrbPrD;
      grSizeQ  <= grSizeD;
      predQ    <= predD;
      iiQ      <= iiD;
      cycQ     <= cycD;
      phaseQ   <= phaseD;
      takenQ   <= takenD;
      exitQ    <= exitD;
      misQ     <= misD;
      takenPQ  <= takenPD;
      exitPQ   <= exitPD;
      prdataQ  <= prdataD;
      preadyQ  <= preadyD;
      pslverrQ <= pslverrD;
    end
  end

  // =====================================================
  // outputs, all from flops
  assign prdata      = prdataQ;
  assign pready      = preadyQ;
  assign pslverr     = pslverrQ;
  // pulses last exactly one cycle after the commit
  assign branchTaken = takenPQ;
  assign loopExit    = exitPQ;

endmodule // mlbu_loop_unit

//--- mlbu_pkg.sv
package mlbu_pkg;

  // =====================================================
  // widths and sizes
  localparam int LCW      = 32;
  localparam int ECW      = 6;
  localparam int RRBW     = 7;
  localparam int PRN      = 48;
  localparam int FRN      = 96;
  localparam int GRMAX    = 96;
  localparam int IIW      = 8;
  localparam int AW       = 8;

  // =====================================================
  // register offsets (byte addresses)
  localparam logic [AW-1:0] OFF_BRANCH  = 8'h00;
  localparam logic [AW-1:0] OFF_LOOPCNT = 8'h04;
  localparam logic [AW-1:0] OFF_EPICNT  = 8'h08;
  localparam logic [AW-1:0] OFF_RRB     = 8'h0c;
  localparam logic [AW-1:0] OFF_GRSIZE  = 8'h10;
  localparam logic [AW-1:0] OFF_PREDLO  = 8'h14;
  localparam logic [AW-1:0] OFF_PREDHI  = 8'h18;
  localparam logic [AW-1:0] OFF_STATUS  = 8'h1c;
  localparam logic [AW-1:0] OFF_IIVAL   = 8'h20;

  // =====================================================
  // field positions
  localparam int BR_OP_LSB    = 0;
  localparam int BR_QP_BIT    = 2;
  localparam int RRB_GR_LSB   = 0;
  localparam int RRB_FR_LSB   = 8;
  localparam int RRB_PR_LSB   = 16;
  localparam int ST_TAKEN     = 0;
  localparam int ST_EXIT      = 1;
  localparam int ST_PHASE_LSB = 2;
  localparam int ST_MISALIGN  = 4;
  localparam int PRED_LO_W    = 32;
  localparam int GR_GRAIN     = 8;

  // =====================================================
  // constants and reset values
  localparam logic [LCW-1:0]  LC_ONE     = 32'h0000_0001;
  localparam logic [ECW-1:0]  EC_ONE     = 6'h01;
  localparam logic [LCW-1:0]  LC_RST     = 32'h0000_0000;
  localparam logic [ECW-1:0]  EC_RST     = 6'h00;
  localparam logic [RRBW-1:0] RRB_RST    = 7'h00;
  localparam logic [RRBW-1:0] GRSIZE_RST = 7'h00;
  localparam logic [IIW-1:0]  II_RST     = 8'h01;
  localparam logic [IIW-1:0]  CYC_MAX    = 8'hff;
  localparam logic [IIW-1:0]  CYC_RST    = 8'h00;
  localparam logic [IIW-1:0]  CYC_ONE    = 8'h01;
  localparam logic [RRBW-1:0] RRB_ONE    = 7'h01;
  localparam logic [3:0]      STRB_ALL   = 4'hf;

  typedef enum logic [1:0] {
    OP_CTOP  = 2'h0,
    OP_CEXIT = 2'h1,
    OP_WTOP  = 2'h2,
    OP_WEXIT = 2'h3
  } mlbu_op_t;

  // gray order along idle -> run -> drain
  typedef enum logic [1:0] {
    PH_IDLE  = 2'h0,
    PH_RUN   = 2'h1,
    PH_DRAIN = 2'h3
  } mlbu_phase_t;

endpackage

//--- mlbu_br_if.sv
`timescale 1ns/1ps
interface mlbu_br_if;
  mlbu_pkg::mlbu_op_t          op;
  logic                        qp;
  logic [mlbu_pkg::LCW-1:0]    lc;
  logic [mlbu_pkg::ECW-1:0]    ec;
  logic [mlbu_pkg::LCW-1:0]    lcNext;
  logic [mlbu_pkg::ECW-1:0]    ecNext;
  logic                        newPred;
  logic                        cont;
  logic                        taken;
  logic                        rotate;

  modport eval (input op, qp, lc, ec, output lcNext, ecNext, newPred, cont, taken, rotate);
  modport core (output op, qp, lc, ec, input lcNext, ecNext, newPred, cont, taken, rotate);
endinterface

//--- mlbu_branch_eval.sv
`timescale 1ns/1ps
module mlbu_branch_eval (
  mlbu_br_if.eval br  // branch request and decision
);

  // =====================================================
  // single-cycle continue/exit decision
  always_comb begin
    logic counted;
    logic top;
    counted    = (br.op == mlbu_pkg::OP_CTOP) || (br.op == mlbu_pkg::OP_CEXIT);
    top        = (br.op == mlbu_pkg::OP_CTOP) || (br.op == mlbu_pkg::OP_WTOP);
    br.lcNext  = br.lc;
    br.ecNext  = br.ec;
    br.newPred = 1'b0;
    br.cont    = 1'b0;
    br.rotate  = 1'b0;
    if (counted && (br.lc != mlbu_pkg::LC_RST)) begin
      br.lcNext  = br.lc - mlbu_pkg::LC_ONE;
      br.newPred = 1'b1;
      br.cont    = 1'b1;
      br.rotate  = 1'b1;
    end else if (!counted && br.qp) begin
      br.cont    = 1'b1;
      br.rotate  = 1'b1;
    end else if (br.ec > mlbu_pkg::EC_ONE) begin
      // continue only while counter above one
      br.ecNext  = br.ec - mlbu_pkg::EC_ONE;
      br.cont    = 1'b1;
      br.rotate  = 1'b1;
    end else if (br.ec == mlbu_pkg::EC_ONE) begin
      br.ecNext  = mlbu_pkg::EC_RST;
      br.rotate  = 1'b1;
    end
    // zero counter: exit without rotating (unrolled-loop corner)
    br.taken = top ? br.cont : !br.cont;
  end

endmodule // mlbu_branch_eval

//--- mlbu_loop_unit_assertions.sv
`timescale 1ns/1ps
module mlbu_chk (
  input wire logic        sys_clk,     // clock
  input wire logic        rst_n,       // reset
  input wire logic        psel,        // select
  input wire logic        penable,     // access
  input wire logic        pwrite,      // direction
  input wire logic [7:0]  paddr,       // address
  input wire logic [31:0] pwdata,      // write data
  input wire logic [3:0]  pstrb,       // strobes
  input wire logic [31:0] prdata,      // read data
  input wire logic        pready,      // ready
  input wire logic        pslverr,     // error
  input wire logic        branchTaken, // taken pulse
  input wire logic        loopExit     // exit pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic brAcc;
  assign brAcc = psel && penable && pwrite && paddr == mlbu_pkg::OFF_BRANCH && pstrb == mlbu_pkg::STRB_ALL;
  sequence s_setup; psel && !penable; endsequence
  sequence s_brDone; brAcc && pready; endsequence
  property p_rdyAfterSetup; s_setup |=> pready; endproperty
  a_rdyAfterSetup: assert property (p_rdyAfterSetup) else $error("no ready after setup");
  property p_rdyOnce; pready |=> !pready; endproperty
  a_rdyOnce: assert property (p_rdyOnce) else $error("ready held too long");
  property p_rdyCause; pready |-> $past(psel && !penable); endproperty
  a_rdyCause: assert property (p_rdyCause) else $error("ready without setup");
  property p_errWithRdy; pslverr |-> pready; endproperty
  a_errWithRdy: assert property (p_errWithRdy) else $error("error outside access");
  property p_unmapped; s_setup ##0 (!pwrite && paddr > mlbu_pkg::OFF_IIVAL) |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_topOneOf; s_brDone ##0 !pwdata[0] |=> branchTaken != loopExit; endproperty
  a_topOneOf: assert property (p_topOneOf) else $error("top branch outcome wrong");
  property p_exitVar; s_brDone ##0 pwdata[0] |=> branchTaken == loopExit; endproperty
  a_exitVar: assert property (p_exitVar) else $error("exit branch outcome wrong");
  property p_takenCause; branchTaken |-> $past(brAcc && pready) ##1 !branchTaken; endproperty
  a_takenCause: assert property (p_takenCause) else $error("stray taken pulse");
  property p_exitCause; loopExit |-> $past(brAcc && pready) ##1 !loopExit; endproperty
  a_exitCause: assert property (p_exitCause) else $error("stray exit pulse");
endmodule // mlbu_chk
bind mlbu_loop_unit mlbu_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .branchTaken(branchTaken), .loopExit(loopExit));

//--- mlbu_loop_prog.sv
`timescale 1ns/1ps
module mlbu_loop_prog (
  input  wire logic       sys_clk,  // core clock
  input  wire logic [1:0] stage,    // 0 prolog, 1 kernel, 2 epilog
  input  wire logic       cmpValid, // compare result ready
  output logic            qp        // branch predicate
);
  initial qp = 1'h0;
  // one in kernel, zero in epilog
  always @(posedge sys_clk) begin
    if (cmpValid) begin
      qp <= (stage == 2'h1);
    end
  end
endmodule // mlbu_loop_prog

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e; logic b; logic t; logic x;} mlbu_exp_t;
  logic        sys_clk = 1'h0;
  logic        rst_n, psel, penable, pwrite, pready, pslverr, branchTaken, loopExit, cmpValid, qp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, lcRand;
  logic [3:0]  pstrb;
  logic [1:0]  stage;
  logic        brPend = 1'h0;
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;
  mlbu_exp_t   q[$];
  mlbu_exp_t   cur, brNote;

  always #20 sys_clk = ~sys_clk;

  mlbu_loop_unit dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .branchTaken(branchTaken), .loopExit(loopExit));
  mlbu_loop_prog prog (.sys_clk(sys_clk), .stage(stage), .cmpValid(cmpValid), .qp(qp));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // =====================================
  // monitor: results against oldest note
  always @(negedge sys_clk) begin
    if (brPend) begin
      brPend = 1'h0;
      chk("branchTaken", {31'h0, brNote.t}, {31'h0, branchTaken});
      chk("loopExit", {31'h0, brNote.x}, {31'h0, loopExit});
    end
    if (pready === 1'h1) begin
      cur = q.pop_front();
      chk("pslverr", {31'h0, cur.e}, {31'h0, pslverr});
      chk("prdata", cur.d, prdata & cur.m);
      if (cur.b) begin
        brNote = cur;
        brPend = 1'h1;
      end
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 2000) begin
      err_count++;
      summarize();
    end
  end

  // =====================================
  // apb master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [31:0] e, input logic [31:0] m, input logic er, input logic b,
                     input logic t, input logic x);
    q.push_back('{e, m, er, b, t, x});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'h1;
    // wait as long as the slave needs; only the bench timeout ends it
    do begin
      @(negedge sys_clk);
    end while (pready !== 1'h1);
    @(posedge sys_clk);
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 4'hf, 32'h0, 32'h0, 1'h0, 1'h0, 1'h0, 1'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    apb(1'h0, a, 32'h0, 4'hf, e, m, 1'h0, 1'h0, 1'h0, 1'h0);
  endtask
  task automatic br(input logic [2:0] c, input logic t, input logic x);
    apb(1'h1, mlbu_pkg::OFF_BRANCH, {29'h0, c}, 4'hf, 32'h0, 32'h0, 1'h0, 1'h1, t, x);
  endtask
  task automatic idle;
    psel <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic setStage(input logic [1:0] st);
    stage <= st;
    cmpValid <= 1'h1;
    @(posedge sys_clk);
    cmpValid <= 1'h0;
    @(posedge sys_clk);
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb, stage, cmpValid} = '0;
    void'($urandom(80));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    rd(mlbu_pkg::OFF_LOOPCNT, 32'h0);
    rd(mlbu_pkg::OFF_EPICNT, 32'h0);
    rd(mlbu_pkg::OFF_RRB, 32'h0);
    apb(1'h0, 8'h40, 32'h0, 4'hf, 32'h0, 32'hffff_ffff, 1'h1, 1'h0, 1'h0, 1'h0);
    apb(1'h1, mlbu_pkg::OFF_LOOPCNT, 32'h5, 4'h3, 32'h0, 32'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    rd(mlbu_pkg::OFF_LOOPCNT, 32'h0);
    // refused values leave the registers alone
    apb(1'h1, mlbu_pkg::OFF_IIVAL, 32'h0, 4'hf, 32'h0, 32'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    rd(mlbu_pkg::OFF_IIVAL, 32'h1);
    apb(1'h1, mlbu_pkg::OFF_GRSIZE, 32'hc, 4'hf, 32'h0, 32'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    // two cycles per branch write, one branch per stage
    wr(mlbu_pkg::OFF_IIVAL, 32'h2);
    // induction values stay outside the rotating gr area
    wr(mlbu_pkg::OFF_GRSIZE, 32'h8);
    rd(mlbu_pkg::OFF_GRSIZE, 32'h8);
    wr(mlbu_pkg::OFF_LOOPCNT, 32'h3);
    wr(mlbu_pkg::OFF_EPICNT, 32'h4);
    wr(mlbu_pkg::OFF_PREDLO, 32'h1);
    repeat (3) br(3'h0, 1'h1, 1'h0);
    rd(mlbu_pkg::OFF_STATUS, 32'h0000_0005);
    rd(mlbu_pkg::OFF_EPICNT, 32'h4);
    repeat (3) br(3'h0, 1'h1, 1'h0);
    br(3'h0, 1'h0, 1'h1);
    // the stage around the two reads ran longer than the interval
    rd(mlbu_pkg::OFF_STATUS, 32'h0000_0012);
    wr(mlbu_pkg::OFF_STATUS, 32'h0000_0010);
    rd(mlbu_pkg::OFF_STATUS, 32'h0000_0002);
    rd(mlbu_pkg::OFF_LOOPCNT, 32'h0);
    rd(mlbu_pkg::OFF_EPICNT, 32'h0);
    rd(mlbu_pkg::OFF_PREDLO, 32'h0000_00f0);
    rd(mlbu_pkg::OFF_PREDHI, 32'h0);
    rd(mlbu_pkg::OFF_RRB, 32'h0029_5901);
    br(3'h1, 1'h1, 1'h1);
    br(3'h0, 1'h0, 1'h1);
    rd(mlbu_pkg::OFF_RRB, 32'h0029_5901);
    lcRand = $urandom();
    wr(mlbu_pkg::OFF_LOOPCNT, lcRand);
    wr(mlbu_pkg::OFF_EPICNT, 32'h2);
    // ones in the upper block expose a rotation that skips its write
    wr(mlbu_pkg::OFF_PREDHI, 32'h0000_ffff);
    idle();
    setStage(2'h1);
    br({qp, 2'h2}, 1'h1, 1'h0);
    idle();
    setStage(2'h2);
    br({qp, 2'h2}, 1'h1, 1'h0);
    br({qp, 2'h2}, 1'h0, 1'h1);
    rd(mlbu_pkg::OFF_LOOPCNT, lcRand);
    rd(mlbu_pkg::OFF_EPICNT, 32'h0);
    rd(mlbu_pkg::OFF_PREDLO, 32'h8, 32'hf);
    wr(mlbu_pkg::OFF_EPICNT, 32'h2);
    br({qp, 2'h3}, 1'h0, 1'h0);
    br({qp, 2'h3}, 1'h1, 1'h1);
    idle();
    repeat (2) @(posedge sys_clk);
    summarize();
  end
endmodule // tb_top
